// ===== src/cfg_port_consts.vh
`ifndef CFG_PORT_CONSTS_VH
`define CFG_PORT_CONSTS_VH

// ----------------------------------------------------------------------------
// clock and synchroniser
// ----------------------------------------------------------------------------
`define CFG_CLK_NS 25
`define CFG_SYNC_LAG 2

// ----------------------------------------------------------------------------
// request glitch rejection
// ----------------------------------------------------------------------------
`define CFG_REQ_REJECT_NS 25
`define CFG_REQ_REJECT_CYC (`CFG_REQ_REJECT_NS / `CFG_CLK_NS)

// ----------------------------------------------------------------------------
// ready handshake low time, bounded by the smallest part's maximum
// ----------------------------------------------------------------------------
`define CFG_READY_LOW_MAX_US 55
`define CFG_READY_LOW_MAX_CYC (`CFG_READY_LOW_MAX_US * 1000 / `CFG_CLK_NS)
`define CFG_CLEAR_CYC (`CFG_READY_LOW_MAX_CYC / 2)

// ----------------------------------------------------------------------------
// master start-up timing, counted after the synchroniser lag
// ----------------------------------------------------------------------------
`define CFG_CS_MIN_NS 100
`define CFG_CS_DLY_CYC ((`CFG_CS_MIN_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS - `CFG_SYNC_LAG)
`define CFG_MCLK_MIN_NS 750
`define CFG_MCLK_DLY_CYC ((`CFG_MCLK_MIN_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS - `CFG_SYNC_LAG)
// half period must exceed the synchroniser lag, else pin b is read as the fall moves it
`define CFG_MCLK_HALF_CYC 3

// ----------------------------------------------------------------------------
// flash read command
// ----------------------------------------------------------------------------
`define CFG_READ_CMD 8'h03
`define CFG_CMD_BYTES 3'h4

`endif

// ===== src/cfg_link_shifter.v
`timescale 1ns/100ps
`default_nettype none

module cfg_link_shifter (
  input wire ref_clk,
  input wire srst,
  input wire clear,
  input wire [7:0] preloadByte,
  input wire sampleEn,
  input wire launchEn,
  input wire bitIn,
  input wire [7:0] nextByte,
  output wire bitOut,
  output reg [7:0] rxByte,
  output reg byteValid
);

  reg [6:0] rxShift;
  reg [7:0] txShift;
  reg [2:0] bitCnt;

  assign bitOut = txShift[7];

  always @(posedge ref_clk) begin
    if (srst) begin
      rxShift <= 7'h00;
      txShift <= 8'h00;
      bitCnt <= 3'h0;
      rxByte <= 8'h00;
      byteValid <= 1'b0;
    end else if (clear) begin
      rxShift <= 7'h00;
      txShift <= preloadByte;
      bitCnt <= 3'h0;
      byteValid <= 1'b0;
    end else begin
      byteValid <= 1'b0;
      if (sampleEn) begin
        rxShift <= {rxShift[5:0], bitIn};
        bitCnt <= bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          rxByte <= {rxShift, bitIn};
          byteValid <= 1'b1;
        end
      end
      // a launch at a byte boundary brings in the next byte's first bit
      if (launchEn) begin
        if (bitCnt == 3'h0) begin
          txShift <= nextByte;
        end else begin
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

endmodule // cfg_link_shifter

`default_nettype wire

// ===== src/config_port_spi_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "cfg_port_consts.vh"

module config_port_spi_sequencer (
  input wire ref_clk,
  input wire srst,
  input wire configRequestN,
  input wire masterModeSel,
  input wire readyIn,
  output wire readyOe,
  output wire readyPullupEn,
  output wire doneOe,
  input wire serialClockIn,
  output reg serialClockOut,
  output wire serialClockOe,
  input wire slaveSelectN,
  output reg flashSelectN,
  output wire flashSelectOe,
  input wire serialPinAIn,
  output wire serialPinAOut,
  output wire serialPinAOe,
  input wire serialPinBIn,
  output wire serialPinBOut,
  output wire serialPinBOe,
  input wire cfgLoadDone,
  output wire [7:0] cfgData,
  output wire cfgDataValid,
  output wire cfgBusy
);

  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_CLEAR = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_LEAD = 3'h3;
  localparam [2:0] S_LOAD = 3'h4;
  localparam [2:0] S_STARTUP = 3'h5;

  localparam I_REQ = 0;
  localparam I_RDY = 1;
  localparam I_CLK = 2;
  localparam I_SEL = 3;
  localparam I_PA = 4;
  localparam I_PB = 5;
  localparam I_MODE = 6;

  localparam integer REJECT_CYC = `CFG_REQ_REJECT_CYC;
  localparam integer CLEAR_CYC = `CFG_CLEAR_CYC - 1;
  localparam integer CS_CYC = `CFG_CS_DLY_CYC;
  localparam integer MCLK_CYC = `CFG_MCLK_DLY_CYC;
  localparam integer DIV_CYC = `CFG_MCLK_HALF_CYC - 1;
  localparam [1:0] REJECT_LAST = REJECT_CYC[1:0];
  localparam [11:0] CLEAR_LAST = CLEAR_CYC[11:0];
  localparam [11:0] CS_LAST = CS_CYC[11:0];
  localparam [11:0] MCLK_LAST = MCLK_CYC[11:0];
  localparam [3:0] DIV_LAST = DIV_CYC[3:0];

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg [6:0] pinMeta;
  reg [6:0] pinSync;
  reg linkClkPrev;

  always @(posedge ref_clk) begin
    if (srst) begin
      // link clock bit resets to its idle low level, so no false edge follows reset
      pinMeta <= 7'h7b;
      pinSync <= 7'h7b;
      linkClkPrev <= 1'b0;
    end else begin
      pinMeta <= {masterModeSel, serialPinBIn, serialPinAIn, slaveSelectN,
                  serialClockIn, readyIn, configRequestN};
      pinSync <= pinMeta;
      linkClkPrev <= pinSync[I_CLK];
    end
  end

  wire linkRise = pinSync[I_CLK] & ~linkClkPrev;
  wire linkFall = ~pinSync[I_CLK] & linkClkPrev;

  // --------------------------------------------------------------------------
  // request glitch filter
  // --------------------------------------------------------------------------
  reg [1:0] reqLowCnt;
  reg reqStart;

  always @(posedge ref_clk) begin
    if (srst) begin
      reqLowCnt <= 2'h0;
      reqStart <= 1'b0;
    end else if (pinSync[I_REQ]) begin
      reqLowCnt <= 2'h0;
      reqStart <= 1'b0;
    end else begin
      if (reqLowCnt != 2'h3) begin
        reqLowCnt <= reqLowCnt + 2'h1;
      end
      // one pulse per low period, only once it outlasts the reject window
      reqStart <= (reqLowCnt == REJECT_LAST);
    end
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  reg [2:0] state;
  reg [11:0] cnt;
  reg modeMaster;

  always @(posedge ref_clk) begin
    if (srst) begin
      state <= S_IDLE;
      cnt <= 12'h000;
      modeMaster <= 1'b0;
    end else if (reqStart) begin
      state <= S_CLEAR;
      cnt <= 12'h000;
      modeMaster <= pinSync[I_MODE];
    end else begin
      cnt <= cnt + 12'h001;
      case (state)
        S_IDLE: begin
          cnt <= 12'h000;
        end
        S_CLEAR: begin
          if (cnt == CLEAR_LAST) begin
            state <= S_WAIT;
            cnt <= 12'h000;
          end
        end
        S_WAIT: begin
          cnt <= 12'h000;
          if (pinSync[I_RDY]) begin
            state <= modeMaster ? S_LEAD : S_LOAD;
          end
        end
        S_LEAD: begin
          if (cnt == MCLK_LAST) begin
            state <= S_LOAD;
            cnt <= 12'h000;
          end
        end
        S_LOAD: begin
          cnt <= 12'h000;
          if (cfgLoadDone) begin
            state <= S_STARTUP;
          end
        end
        S_STARTUP: begin
          cnt <= 12'h000;
        end
        default: begin
          state <= S_IDLE;
          cnt <= 12'h000;
        end
      endcase
    end
  end

  wire loading = (state == S_LOAD);
  wire masterLoad = modeMaster & loading;
  wire slaveActive = ~modeMaster & loading & ~pinSync[I_SEL];

  // --------------------------------------------------------------------------
  // handshake pins
  // --------------------------------------------------------------------------
  assign readyOe = (state == S_CLEAR);
  assign readyPullupEn = (state == S_WAIT) | (state == S_LEAD) | loading;
  assign doneOe = (state != S_STARTUP);
  assign cfgBusy = (state != S_IDLE) & (state != S_STARTUP);

  // --------------------------------------------------------------------------
  // master clock and flash select
  // --------------------------------------------------------------------------
  reg [3:0] divCnt;
  wire divTick = masterLoad & (divCnt == 4'h0);

  always @(posedge ref_clk) begin
    if (srst) begin
      divCnt <= 4'h0;
      serialClockOut <= 1'b0;
      flashSelectN <= 1'b1;
    end else begin
      if (!masterLoad) begin
        divCnt <= 4'h0;
        serialClockOut <= 1'b0;
      end else begin
        divCnt <= (divCnt == DIV_LAST) ? 4'h0 : divCnt + 4'h1;
        if (divTick) begin
          serialClockOut <= ~serialClockOut;
        end
      end
      if (reqStart || (state == S_STARTUP) || !modeMaster) begin
        flashSelectN <= 1'b1;
      end else if (state == S_LEAD && cnt == CS_LAST) begin
        flashSelectN <= 1'b0;
      end
    end
  end

  wire masterRise = divTick & ~serialClockOut;
  wire masterFall = divTick & serialClockOut;

  assign serialClockOe = masterLoad;
  assign flashSelectOe = modeMaster & ((state == S_LEAD) | loading);

  // --------------------------------------------------------------------------
  // serial data path
  // --------------------------------------------------------------------------
  reg [2:0] cmdIdx;
  wire [7:0] rxByte;
  wire rxValid;
  wire txBit;
  wire shiftClear = modeMaster ? ~loading : pinSync[I_SEL];
  wire sampleEn = modeMaster ? masterRise : (slaveActive & linkRise);
  wire launchEn = modeMaster ? masterFall : (slaveActive & linkFall);
  wire rxBit = modeMaster ? pinSync[I_PB] : pinSync[I_PA];
  wire [7:0] masterByte = (cmdIdx == 3'h0) ? `CFG_READ_CMD : 8'h00;
  wire [7:0] statusByte = {5'h00, state};
  wire [7:0] txByte = modeMaster ? masterByte : statusByte;

  cfg_link_shifter shifter (
    .ref_clk(ref_clk),
    .srst(srst),
    .clear(shiftClear),
    .preloadByte(txByte),
    .sampleEn(sampleEn),
    .launchEn(launchEn),
    .bitIn(rxBit),
    .nextByte(txByte),
    .bitOut(txBit),
    .rxByte(rxByte),
    .byteValid(rxValid)
  );

  // command bytes are counted so their echoes are not passed on as data
  always @(posedge ref_clk) begin
    if (srst || !loading) begin
      cmdIdx <= 3'h0;
    end else if (masterLoad && rxValid && cmdIdx != `CFG_CMD_BYTES) begin
      cmdIdx <= cmdIdx + 3'h1;
    end
  end

  assign serialPinAOut = txBit;
  assign serialPinAOe = masterLoad;
  assign serialPinBOut = txBit;
  assign serialPinBOe = slaveActive;

  assign cfgData = rxByte;
  assign cfgDataValid = rxValid & (~modeMaster | (cmdIdx == `CFG_CMD_BYTES));

endmodule // config_port_spi_sequencer

`default_nettype wire

// ===== verif/config_port_spi_checker.sv
`timescale 1ns/100ps
`default_nettype none
module config_port_spi_checker (
  input wire ref_clk,
  input wire srst,
  input wire configRequestN,
  input wire masterModeSel,
  input wire readyIn,
  input wire readyOe,
  input wire readyPullupEn,
  input wire doneOe,
  input wire serialClockOut,
  input wire serialClockOe,
  input wire slaveSelectN,
  input wire flashSelectN,
  input wire serialPinAOe,
  input wire serialPinBOe,
  input wire cfgLoadDone,
  input wire cfgDataValid,
  input wire cfgBusy
);
  reg [11:0] lowCnt;
  reg [11:0] since;
  reg armed;
  reg rdyQ;
  wire rdyRise = readyIn & ~rdyQ & cfgBusy & masterModeSel;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------------------
  // ready low time and master start-up counters
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    rdyQ <= readyIn;
    if (srst) begin
      lowCnt <= 12'h0;
      since <= 12'h0;
      armed <= 1'b0;
    end else begin
      lowCnt <= readyOe ? lowCnt + 12'h1 : 12'h0;
      since <= rdyRise ? 12'h0 : since + 12'h1;
      if (rdyRise) armed <= 1'b1;
      else if (serialClockOut) armed <= 1'b0;
    end
  end
  a_ready_bound: assert property (lowCnt <= 12'h898)
    else $error("ready held low too long");
  a_glitch_reject: assert property (!readyOe && configRequestN ##1 !configRequestN ##1 configRequestN |-> !readyOe [*5])
    else $error("short request low accepted");
  a_request_take: assert property (configRequestN ##1 !configRequestN [*3] |-> ##[0:4] readyOe)
    else $error("request not taken");
  a_master_select: assert property (rdyRise |-> ##[4:8] $fell(flashSelectN))
    else $error("flash select delay off");
  a_first_clock: assert property (armed && $rose(serialClockOut) |-> since >= 12'h1d && since <= 12'h27)
    else $error("first clock edge delay off");
  a_clock_dir: assert property (serialClockOe |-> masterModeSel && !serialPinBOe)
    else $error("clock driven in slave mode");
  a_pin_a_dir: assert property (serialPinAOe |-> masterModeSel)
    else $error("pin a driven in slave mode");
  a_pin_b_dir: assert property (serialPinBOe |-> !masterModeSel)
    else $error("pin b driven in master mode");
  a_select_gate: assert property ((!masterModeSel && slaveSelectN) [*4] |-> !cfgDataValid && !serialPinBOe)
    else $error("slave traffic while deselected");
  a_done_cause: assert property ($fell(doneOe) |-> $past(cfgLoadDone))
    else $error("done released without load end");
  a_pullup_wait: assert property ($fell(readyOe) && cfgBusy |-> readyPullupEn)
    else $error("pull-up off while configuring");
  c_master: cover property (rdyRise);
  c_slave_byte: cover property (cfgDataValid && !masterModeSel);
  c_done: cover property ($fell(doneOe));
endmodule // config_port_spi_checker
bind config_port_spi_sequencer config_port_spi_checker chk_u (.ref_clk(ref_clk), .srst(srst),
  .configRequestN(configRequestN), .masterModeSel(masterModeSel), .readyIn(readyIn),
  .readyOe(readyOe), .readyPullupEn(readyPullupEn), .doneOe(doneOe),
  .serialClockOut(serialClockOut), .serialClockOe(serialClockOe), .slaveSelectN(slaveSelectN),
  .flashSelectN(flashSelectN), .serialPinAOe(serialPinAOe), .serialPinBOe(serialPinBOe),
  .cfgLoadDone(cfgLoadDone), .cfgDataValid(cfgDataValid), .cfgBusy(cfgBusy));
`default_nettype wire

// ===== verif/spi_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_flash_model (
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] cmdByte
);
  integer idx;
  // byte n of the stream is a0 + n, msb first
  function automatic logic bitAt(input integer k);
    logic [7:0] b;
    b = 8'ha0 + 8'(k / 8);
    return b[7 - k % 8];
  endfunction
  initial begin
    idx = 0;
    miso = 1'b0;
    cmdByte = 8'h00;
  end
  always @(negedge selN) begin
    idx = 0;
    miso <= #2 bitAt(0);
  end
  always @(negedge sclk) if (!selN) begin
    idx = idx + 1;
    miso <= #2 bitAt(idx);
  end
  // released line shows the inverse of the last bit
  always @(posedge selN) miso <= #2 ~miso;
  always @(posedge sclk) if (!selN && idx < 8) cmdByte <= {cmdByte[6:0], mosi};
endmodule // spi_flash_model
`default_nettype wire

// ===== verif/config_port_spi_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module config_port_spi_sequencer_bench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic reqN = 1'b1;
  logic mSel = 1'b0;
  logic sclkIn = 1'b0;
  logic ssN = 1'b1;
  logic pinA = 1'b0;
  logic loadDone = 1'b0;
  logic [7:0] got;
  logic [7:0] lastByte = 8'h00;
  wire readyOe, pullEn, doneOe, sclkOut, sclkOe, fselN, fselOe, aOut, aOe, bOut, bOe, busy, valid;
  wire miso;
  wire [7:0] data;
  wire [7:0] cmd;
  wire fselWire = fselOe ? fselN : 1'b1;
  integer num_errors = 0;
  integer tests_run = 0;
  integer byteCnt = 0;
  integer i;
  integer n;
  config_port_spi_sequencer dut_u (.ref_clk(ref_clk), .srst(srst), .configRequestN(reqN),
    .masterModeSel(mSel), .readyIn(~readyOe), .readyOe(readyOe), .readyPullupEn(pullEn),
    .doneOe(doneOe), .serialClockIn(sclkIn), .serialClockOut(sclkOut), .serialClockOe(sclkOe),
    .slaveSelectN(ssN), .flashSelectN(fselN), .flashSelectOe(fselOe), .serialPinAIn(pinA),
    .serialPinAOut(aOut), .serialPinAOe(aOe), .serialPinBIn(bOe ? bOut : miso),
    .serialPinBOut(bOut), .serialPinBOe(bOe), .cfgLoadDone(loadDone), .cfgData(data),
    .cfgDataValid(valid), .cfgBusy(busy));
  spi_flash_model flash_u (.sclk(sclkOe & sclkOut), .selN(fselWire), .mosi(aOut), .miso(miso),
    .cmdByte(cmd));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (valid === 1'b1) begin
    lastByte <= data;
    byteCnt <= byteCnt + 1;
  end
  // ---------------------------------------------------------------------------
  // helpers and scenarios
  // ---------------------------------------------------------------------------
  task check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task request(input logic master, input integer lowCyc);
    mSel = master;
    reqN = 1'b0;
    tick(lowCyc);
    reqN = 1'b1;
  endtask
  task t_glitch;
    request(1'b0, 1);
    tick(10);
    check({readyOe, busy}, 2'b00);
  endtask
  task t_start(input logic master);
    request(master, 4);
    n = 0;
    while (readyOe !== 1'b1 && n < 10) begin tick(1); n++; end
    check({readyOe, busy, doneOe}, 3'b111);
    n = 0;
    while (readyOe !== 1'b0 && n < 3000) begin tick(1); n++; end
    check(n > 0 && n <= 2200, 1);
    check(pullEn, 1);
  endtask
  task t_master;
    t_start(1'b1);
    n = 0;
    while (fselN !== 1'b0 && n < 20) begin tick(1); n++; end
    check(n >= 4 && n <= 8, 1);
    while (sclkOut !== 1'b1 && n < 60) begin tick(1); n++; end
    check(n >= 30 && n <= 40, 1);
    check({sclkOe, fselOe, aOe, bOe}, 4'b1110);
    n = 0;
    while (byteCnt < 1 && n < 400) begin tick(1); n++; end
    check(lastByte, 8'ha4);
    check(cmd, 8'h03);
    loadDone = 1'b1;
    tick(1);
    loadDone = 1'b0;
    tick(2);
    check({doneOe, sclkOe, fselWire}, 3'b001);
  endtask
  task sbyte(input logic [7:0] v, input integer nb);
    ssN = 1'b0;
    #137;
    for (i = 7; i > 7 - nb; i--) begin
      pinA = v[i];
      #100 sclkIn = 1'b1;
      #99 got[i] = bOut;
      #1 sclkIn = 1'b0;
    end
    #100 ssN = 1'b1;
    #300;
  endtask
  task t_slave;
    t_start(1'b0);
    tick(4);
    n = byteCnt;
    sbyte(8'h0f, 4);
    check(byteCnt == n, 1);
    sbyte(8'hc3, 8);
    check(byteCnt == n + 1, 1);
    check(lastByte, 8'hc3);
    check(got, 8'h04);
    check({sclkOe, aOe, bOe}, 3'b000);
  endtask
  initial begin
    #300000;
    num_errors++;
    conclude;
  end
  initial begin
    tick(12);
    srst = 1'b0;
    tick(2);
    t_glitch;
    t_master;
    t_slave;
    conclude;
  end
endmodule // config_port_spi_sequencer_bench
`default_nettype wire
